//--- hdl/usart_pkg.sv
package usart_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_CSA    = 3'h1;
    localparam logic [2:0] ADDR_CSB    = 3'h2;
    localparam logic [2:0] ADDR_CSC    = 3'h3;
    localparam logic [2:0] ADDR_BAUD_L = 3'h4;
    localparam logic [2:0] ADDR_BAUD_H = 3'h5;

    // control_status_first bit positions
    localparam int CSA_RX_DONE  = 7;
    localparam int CSA_TX_DONE  = 6;
    localparam int CSA_TX_EMPTY = 5;
    localparam int CSA_FRAME    = 4;
    localparam int CSA_OVERRUN  = 3;
    localparam int CSA_PARITY   = 2;
    localparam int CSA_DOUBLE   = 1;

    // control_status_second bit positions
    localparam int CSB_RX_IE    = 7;
    localparam int CSB_TXD_IE   = 6;
    localparam int CSB_TXE_IE   = 5;
    localparam int CSB_RX_ON    = 4;
    localparam int CSB_TX_ON    = 3;
    localparam int CSB_SIZE2    = 2;
    localparam int CSB_RX_NINTH = 1;
    localparam int CSB_TX_NINTH = 0;

    // third control register bit positions
    localparam int CSC_SYNC     = 6;
    localparam int CSC_PAR_EN   = 5;
    localparam int CSC_PAR_ODD  = 4;
    localparam int CSC_STOP2    = 3;
    localparam int CSC_SIZE_HI  = 2;
    localparam int CSC_SIZE_LO  = 1;

    // values after reset
    localparam logic [1:0]  RST_SIZE_LO = 2'h3;
    localparam logic [11:0] RST_BAUD    = 12'h000;

    // size code of 9-bit characters
    localparam logic [2:0] SIZE_NINE = 3'h7;

    // last oversampling tick count of a bit (ticks per bit minus one), normal and double speed
    localparam logic [3:0] TICKS_NORMAL = 4'hF;
    localparam logic [3:0] TICKS_DOUBLE = 4'h7;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_START = 3'b010,
        RX_DATA  = 3'b100
    } rx_state_t;

endpackage

//--- hdl/usart_datapath.sv
`timescale 1ns/1ns
// Overview of operation
// [RULE1] cpu write to data location fills transmit buffer and starts sending
// [RULE2] buffer moves to shifter when idle or right after last stop bit
// [RULE3] loaded shifter sends a whole frame at baud or sync clock rate
// [RULE4] surplus high bits of short characters are ignored on transmit
// [RULE5] software writes transmit ninth bit before the low byte
// [RULE6] buffer-empty flag high while buffer empty, low while data waits
// [RULE7] software writes zero at buffer-empty position of first control register
// [RULE8] buffer-empty request stays while flag, enable and global enable are high
// [RULE9] data write clears buffer-empty flag
// [RULE10] transmit-complete set when frame shifted out and buffer empty
// [RULE11] transmit-complete cleared on interrupt service or written one
// [RULE12] transmit-complete request when flag set, enabled, globally enabled
// [RULE13] parity enabled puts parity between last data bit and first stop
// [RULE14] transmitter disable waits for shifter and buffer empty, then releases pin
// [RULE15] receiver enable takes over serial input pin
// [RULE16] sync mode receiver uses external clock pin as bit clock
// [RULE17] receive starts on valid start bit, samples bits up to first stop
// [RULE18] second stop bit is ignored by receiver
// [RULE19] after first stop frame goes to receive buffer, readable at data location
// [RULE20] unused high bits of short received characters read as zero
// [RULE21] receive-complete flag shows unread data in receive buffer
// [RULE22] status and ninth bit buffered with data, data read advances buffer
// [RULE23] framing error only when first stop bit sampled low
// [RULE24] parity is xor of data bits, inverted for odd parity
// [RULE25] transmitter enable takes over serial output pin
module usart_datapath
    import usart_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       GIE_I,
    input  wire logic       TX_DONE_ACK_I,
    input  wire logic       SER_IN_I,
    input  wire logic       SYNC_CLK_I,
    output logic            SER_OUT_O,
    output logic            SER_OUT_OE_O,
    output logic            RX_PIN_OWN_O,
    output logic            TX_EMPTY_IRQ_O,
    output logic            TX_DONE_IRQ_O,
    output logic            RX_DONE_IRQ_O
);

    typedef struct packed {
        logic        rx_s1;
        logic        rx_s2;
        logic        ck_s1;
        logic        ck_s2;
        logic        ck_s3;
        logic [7:0]  rdata;
        logic        dbl;
        logic        rx_ie;
        logic        txd_ie;
        logic        txe_ie;
        logic        rx_en;
        logic        tx_en;
        logic        size2;
        logic        tx_ninth;
        logic        sync;
        logic        par_en;
        logic        par_odd;
        logic        stop2;
        logic [1:0]  size_lo;
        logic [11:0] baud;
        logic [11:0] pre_cnt;
        logic [8:0]  tx_buf;
        logic        tx_full;
        logic        tx_busy;
        logic [12:0] tx_sh;
        logic [3:0]  tx_left;
        logic [3:0]  tx_cnt;
        logic        tx_on;
        logic        tx_done;
        logic        txd;
        rx_state_t   rx_state;
        logic [3:0]  rx_cnt;
        logic [3:0]  rx_idx;
        logic [10:0] rx_sh;
        logic [8:0]  rx_buf;
        logic        rx_full;
        logic        fe;
        logic        dor;
        logic        upe;
        logic        irq_txe;
        logic        irq_txd;
        logic        irq_rx;
    } state_t;

    state_t q_r;
    state_t q_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [3:0] data_bits(input logic [2:0] code);
        unique case (code)
            3'h0:    data_bits = 4'h5;
            3'h1:    data_bits = 4'h6;
            3'h2:    data_bits = 4'h7;
            3'h7:    data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // zero the bits above the character length
    function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] n);
        logic [8:0] m;
        m = 9'h000;
        for (int i = 0; i < 9; i++) begin
            m[i] = d[i] & (i < int'(n));
        end
        return m;
    endfunction

    function automatic logic parity(input logic [8:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [2:0]  size;
    logic [3:0]  nbits;
    logic [3:0]  bit_ticks;
    logic        tick;
    logic        ck_rise;
    logic        ck_fall;
    logic        tx_step;
    logic        rx_sample;
    logic        frame_end;
    logic [8:0]  tx_data;
    logic [8:0]  rx_data;
    logic [3:0]  rx_total;
    logic [3:0]  tx_len;
    logic [12:0] frame;

    always_comb begin
        q_nxt     = q_r;
        size      = {q_r.size2, q_r.size_lo};
        nbits     = data_bits(size);
        bit_ticks = q_r.dbl ? TICKS_DOUBLE : TICKS_NORMAL;
        tick      = (q_r.pre_cnt == 12'h000);
        // edge detectors read only the second and third stages
        ck_rise   = q_r.ck_s2 & ~q_r.ck_s3;
        ck_fall   = ~q_r.ck_s2 & q_r.ck_s3;
        frame_end = 1'b0;
        rx_sample = 1'b0;
        tx_data   = 9'h000;
        rx_data   = 9'h000;
        tx_len    = 4'h0;
        frame     = 13'h1FFF;
        rx_total  = nbits + {3'h0, q_r.par_en} + 4'h1;

        q_nxt.rx_s1 = SER_IN_I;
        q_nxt.rx_s2 = q_r.rx_s1;
        q_nxt.ck_s1 = SYNC_CLK_I;
        q_nxt.ck_s2 = q_r.ck_s1;
        q_nxt.ck_s3 = q_r.ck_s2;

        // oversampling prescaler from the baud divisor
        q_nxt.pre_cnt = tick ? q_r.baud : q_r.pre_cnt - 12'h001;

        // [RULE3] bit clock source
        tx_step = q_r.sync ? ck_rise : (tick && q_r.tx_cnt == bit_ticks);

        // transmit shifter
        if (q_r.tx_busy) begin
            if (tick && !q_r.sync) begin
                q_nxt.tx_cnt = (q_r.tx_cnt == bit_ticks) ? 4'h0 : q_r.tx_cnt + 4'h1;
            end
            if (tx_step) begin
                if (q_r.tx_left == 4'h1) begin
                    frame_end     = 1'b1;
                    q_nxt.tx_busy = 1'b0;
                    q_nxt.txd     = 1'b1;
                end else begin
                    q_nxt.tx_sh   = {1'b1, q_r.tx_sh[12:1]};
                    q_nxt.txd     = q_r.tx_sh[1];
                    q_nxt.tx_left = q_r.tx_left - 4'h1;
                end
            end
        end

        // [RULE2] load when idle or right after the last stop bit
        if (!q_nxt.tx_busy && q_r.tx_full && q_r.tx_on) begin
            // [RULE4] drop surplus high bits
            tx_data = mask_data(q_r.tx_buf, nbits);
            frame[0] = 1'b0;
            for (int i = 0; i < 9; i++) begin
                if (i < int'(nbits)) begin
                    frame[i + 1] = tx_data[i];
                end
            end
            // [RULE13] parity after last data bit
            if (q_r.par_en) begin
                // [RULE24] parity sense
                frame[nbits + 4'h1] = parity(tx_data, q_r.par_odd);
            end
            tx_len = nbits + {3'h0, q_r.par_en} + 4'h2 + {3'h0, q_r.stop2};
            q_nxt.tx_sh   = frame;
            q_nxt.tx_left = tx_len;
            q_nxt.tx_busy = 1'b1;
            q_nxt.tx_cnt  = 4'h0;
            q_nxt.txd     = 1'b0;
            // [RULE6] buffer emptied by the move
            q_nxt.tx_full = 1'b0;
        end

        // [RULE11] clear on service or on written one, set below wins
        if (TX_DONE_ACK_I) begin
            q_nxt.tx_done = 1'b0;
        end
        if (WR_I && ADDR_I == ADDR_CSA && WDATA_I[CSA_TX_DONE]) begin
            q_nxt.tx_done = 1'b0;
        end

        // [RULE10] frame done with nothing waiting
        if (frame_end && !q_r.tx_full) begin
            q_nxt.tx_done = 1'b1;
        end

        // [RULE14] disable only once shifter and buffer are empty
        if (q_r.tx_en) begin
            // [RULE25] take over the output pin
            q_nxt.tx_on = 1'b1;
        end else if (!q_nxt.tx_busy && !q_r.tx_full) begin
            q_nxt.tx_on = 1'b0;
        end

        // receiver
        rx_sample = q_r.sync ? ck_fall : (tick && q_r.rx_cnt == bit_ticks);
        if (tick && !q_r.sync) begin
            q_nxt.rx_cnt = q_r.rx_cnt + 4'h1;
        end
        unique case (q_r.rx_state)
            RX_IDLE: begin
                q_nxt.rx_cnt = 4'h0;
                q_nxt.rx_idx = 4'h0;
                // [RULE17] start bit detection
                if (q_r.rx_en && !q_r.rx_s2) begin
                    if (!q_r.sync) begin
                        q_nxt.rx_state = RX_START;
                    // [RULE16] sync clock samples the start bit
                    end else if (ck_fall) begin
                        q_nxt.rx_state = RX_DATA;
                    end
                end
            end
            RX_START: begin
                // mid-bit recheck rejects glitches shorter than half a bit
                if (tick && q_r.rx_cnt == {1'b0, bit_ticks[3:1]}) begin
                    q_nxt.rx_cnt   = 4'h0;
                    q_nxt.rx_state = q_r.rx_s2 ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_sample) begin
                    q_nxt.rx_cnt = 4'h0;
                    q_nxt.rx_sh[q_r.rx_idx] = q_r.rx_s2;
                    q_nxt.rx_idx = q_r.rx_idx + 4'h1;
                    // [RULE18] stop after the first stop bit
                    if (q_r.rx_idx == rx_total - 4'h1) begin
                        q_nxt.rx_state = RX_IDLE;
                    end
                end
            end
            default: q_nxt.rx_state = RX_IDLE;
        endcase
        // [RULE15] receiver off leaves the pin alone
        if (!q_r.rx_en) begin
            q_nxt.rx_state = RX_IDLE;
        end

        // [RULE22] data read advances the receive buffer
        if (RD_I && ADDR_I == ADDR_DATA) begin
            q_nxt.rx_full = 1'b0;
        end

        // [RULE19] frame moves into the receive buffer
        if (q_r.rx_state == RX_DATA && rx_sample && q_r.rx_idx == rx_total - 4'h1) begin
            if (q_nxt.rx_full) begin
                q_nxt.dor = 1'b1;
            end else begin
                // [RULE20] zero the unused high bits
                rx_data = mask_data(q_nxt.rx_sh[8:0], nbits);
                q_nxt.rx_buf = rx_data;
                // [RULE21] unread data present
                q_nxt.rx_full = 1'b1;
                q_nxt.dor = 1'b0;
                // [RULE23] only the first stop bit counts
                q_nxt.fe = ~q_r.rx_s2;
                q_nxt.upe = q_r.par_en
                          && (parity(rx_data, q_r.par_odd) != q_nxt.rx_sh[nbits]);
            end
        end

        // register writes
        if (WR_I) begin
            unique case (ADDR_I)
                ADDR_DATA: begin
                    // [RULE1] fill the transmit buffer
                    q_nxt.tx_buf = {q_r.tx_ninth, WDATA_I};
                    // [RULE9] clear buffer-empty
                    q_nxt.tx_full = 1'b1;
                end
                // [RULE7] buffer-empty position ignores the written value
                ADDR_CSA: q_nxt.dbl = WDATA_I[CSA_DOUBLE];
                ADDR_CSB: begin
                    q_nxt.rx_ie    = WDATA_I[CSB_RX_IE];
                    q_nxt.txd_ie   = WDATA_I[CSB_TXD_IE];
                    q_nxt.txe_ie   = WDATA_I[CSB_TXE_IE];
                    q_nxt.rx_en    = WDATA_I[CSB_RX_ON];
                    q_nxt.tx_en    = WDATA_I[CSB_TX_ON];
                    q_nxt.size2    = WDATA_I[CSB_SIZE2];
                    // [RULE5] ninth bit latched ahead of the low byte
                    q_nxt.tx_ninth = WDATA_I[CSB_TX_NINTH];
                end
                ADDR_CSC: begin
                    q_nxt.sync    = WDATA_I[CSC_SYNC];
                    q_nxt.par_en  = WDATA_I[CSC_PAR_EN];
                    q_nxt.par_odd = WDATA_I[CSC_PAR_ODD];
                    q_nxt.stop2   = WDATA_I[CSC_STOP2];
                    q_nxt.size_lo = WDATA_I[CSC_SIZE_HI:CSC_SIZE_LO];
                end
                ADDR_BAUD_L: q_nxt.baud[7:0] = WDATA_I;
                ADDR_BAUD_H: q_nxt.baud[11:8] = WDATA_I[3:0];
                default: ;
            endcase
        end

        // register reads, data valid the cycle after the strobe
        q_nxt.rdata = 8'h00;
        if (RD_I) begin
            unique case (ADDR_I)
                ADDR_DATA: q_nxt.rdata = q_r.rx_buf[7:0];
                ADDR_CSA: begin
                    q_nxt.rdata[CSA_RX_DONE]  = q_r.rx_full;
                    q_nxt.rdata[CSA_TX_DONE]  = q_r.tx_done;
                    q_nxt.rdata[CSA_TX_EMPTY] = ~q_r.tx_full;
                    q_nxt.rdata[CSA_FRAME]    = q_r.fe;
                    q_nxt.rdata[CSA_OVERRUN]  = q_r.dor;
                    q_nxt.rdata[CSA_PARITY]   = q_r.upe;
                    q_nxt.rdata[CSA_DOUBLE]   = q_r.dbl;
                end
                ADDR_CSB: begin
                    q_nxt.rdata[CSB_RX_IE]    = q_r.rx_ie;
                    q_nxt.rdata[CSB_TXD_IE]   = q_r.txd_ie;
                    q_nxt.rdata[CSB_TXE_IE]   = q_r.txe_ie;
                    q_nxt.rdata[CSB_RX_ON]    = q_r.rx_en;
                    q_nxt.rdata[CSB_TX_ON]    = q_r.tx_en;
                    q_nxt.rdata[CSB_SIZE2]    = q_r.size2;
                    q_nxt.rdata[CSB_RX_NINTH] = q_r.rx_buf[8];
                    q_nxt.rdata[CSB_TX_NINTH] = q_r.tx_ninth;
                end
                ADDR_CSC: begin
                    q_nxt.rdata[CSC_SYNC]    = q_r.sync;
                    q_nxt.rdata[CSC_PAR_EN]  = q_r.par_en;
                    q_nxt.rdata[CSC_PAR_ODD] = q_r.par_odd;
                    q_nxt.rdata[CSC_STOP2]   = q_r.stop2;
                    q_nxt.rdata[CSC_SIZE_HI:CSC_SIZE_LO] = q_r.size_lo;
                end
                ADDR_BAUD_L: q_nxt.rdata = q_r.baud[7:0];
                ADDR_BAUD_H: q_nxt.rdata = {4'h0, q_r.baud[11:8]};
                default: ;
            endcase
        end

        // requests change in the same cycle as the flags, straight from flops
        // [RULE8] level request while buffer empty
        q_nxt.irq_txe = ~q_nxt.tx_full & q_nxt.txe_ie & GIE_I;
        // [RULE12] request from the flag
        q_nxt.irq_txd = q_nxt.tx_done & q_nxt.txd_ie & GIE_I;
        q_nxt.irq_rx  = q_nxt.rx_full & q_nxt.rx_ie & GIE_I;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            q_r          <= '0;
            q_r.rx_s1    <= 1'b1;
            q_r.rx_s2    <= 1'b1;
            q_r.txd      <= 1'b1;
            q_r.tx_sh    <= 13'h1FFF;
            q_r.size_lo  <= RST_SIZE_LO;
            q_r.baud     <= RST_BAUD;
            q_r.rx_state <= RX_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign RDATA_O        = q_r.rdata;
    assign SER_OUT_O      = q_r.txd;
    assign SER_OUT_OE_O   = q_r.tx_on;
    assign RX_PIN_OWN_O   = q_r.rx_en;
    assign TX_EMPTY_IRQ_O = q_r.irq_txe;
    assign TX_DONE_IRQ_O  = q_r.irq_txd;
    assign RX_DONE_IRQ_O  = q_r.irq_rx;

endmodule

//--- tb/usart_sva.sv
`timescale 1ns/1ns
module usart_sva
    import usart_pkg::*;
(
    input wire logic       REF_CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic       GIE_I,
    input wire logic       TX_DONE_ACK_I,
    input wire logic       SER_OUT_O,
    input wire logic       SER_OUT_OE_O,
    input wire logic       RX_PIN_OWN_O,
    input wire logic       TX_EMPTY_IRQ_O,
    input wire logic       TX_DONE_IRQ_O,
    input wire logic       RX_DONE_IRQ_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    ////////////////////////////////////////////////////////////////
    property p_wr_empty;
        WR_I && ADDR_I == ADDR_DATA |=> !TX_EMPTY_IRQ_O;
    endproperty
    a_wr_empty: assert property (p_wr_empty)
        else $error("empty request after data write");
    property p_gie;
        !GIE_I |=> !(TX_EMPTY_IRQ_O || TX_DONE_IRQ_O || RX_DONE_IRQ_O);
    endproperty
    a_gie: assert property (p_gie)
        else $error("request without global enable");
    property p_release;
        $fell(SER_OUT_OE_O) |-> SER_OUT_O && $past(SER_OUT_O);
    endproperty
    a_release: assert property (p_release)
        else $error("output released mid frame");
    property p_done_clr;
        (TX_DONE_ACK_I || WR_I && ADDR_I == ADDR_CSA && WDATA_I[CSA_TX_DONE])
            && TX_DONE_IRQ_O |=> ##1 !TX_DONE_IRQ_O;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("done request not cleared");
    property p_done_gie;
        TX_DONE_IRQ_O |-> $past(GIE_I);
    endproperty
    a_done_gie: assert property (p_done_gie)
        else $error("done request with global enable low");
    property p_rx_own;
        WR_I && ADDR_I == ADDR_CSB |-> ##2 RX_PIN_OWN_O == $past(WDATA_I[CSB_RX_ON], 2);
    endproperty
    a_rx_own: assert property (p_rx_own)
        else $error("input pin ownership wrong");
    property p_tx_own;
        WR_I && ADDR_I == ADDR_CSB && WDATA_I[CSB_TX_ON] |-> ##2 SER_OUT_OE_O;
    endproperty
    a_tx_own: assert property (p_tx_own)
        else $error("output pin not taken");
    property p_rd_clr;
        RD_I && ADDR_I == ADDR_DATA |=> ##1 !RX_DONE_IRQ_O;
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("receive request after data read");
endmodule

bind usart_datapath usart_sva i_usart_sva (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .GIE_I(GIE_I), .TX_DONE_ACK_I(TX_DONE_ACK_I),
    .SER_OUT_O(SER_OUT_O), .SER_OUT_OE_O(SER_OUT_OE_O), .RX_PIN_OWN_O(RX_PIN_OWN_O),
    .TX_EMPTY_IRQ_O(TX_EMPTY_IRQ_O), .TX_DONE_IRQ_O(TX_DONE_IRQ_O),
    .RX_DONE_IRQ_O(RX_DONE_IRQ_O)
);

//--- tb/usart_station.sv
`timescale 1ns/1ns
module usart_station #(
    parameter int BIT_NS  = 1600,
    parameter int SYNC_NS = 800
) (
    input  wire logic       ser_out_i,
    input  wire logic [3:0] nbits_i,
    input  wire logic       par_i,
    input  wire logic       sync_i,
    output logic            ser_in_o,
    output logic            sync_clk_o
);
    logic [11:0] got_q[$];
    logic [11:0] w;
    initial begin
        ser_in_o   = 1'b1;
        sync_clk_o = 1'b0;
    end
    // link clock only runs inside frames
    task automatic pulse;
        sync_clk_o = 1'b1;
        #(SYNC_NS / 2);
        sync_clk_o = 1'b0;
        #(SYNC_NS / 2);
    endtask
    task automatic bit_out(input logic b, input int t);
        ser_in_o = b;
        if (sync_i) begin
            pulse();
        end else begin
            #t;
        end
    endtask
    // a low stop bit is cut short so its end never looks like a new start
    task automatic send(input logic [11:0] f, input int cnt);
        bit_out(1'b0, BIT_NS);
        for (int i = 0; i < cnt; i++) begin
            bit_out(f[i], (i == cnt - 1 && !f[i]) ? BIT_NS * 6 / 10 : BIT_NS);
        end
        ser_in_o = 1'b1;
        if (!sync_i) begin
            #BIT_NS;
        end
    endtask
    // capture data, parity and first stop, lsb first; sync samples late in the period
    always @(negedge ser_out_i) begin
        w = '0;
        if (!sync_i) begin
            #(BIT_NS / 2);
        end
        for (int i = 0; i < nbits_i + par_i + 1; i++) begin
            if (sync_i) begin
                pulse();
            end else begin
                #BIT_NS;
            end
            w[i] = ser_out_i;
        end
        if (sync_i) begin
            pulse();
        end
        got_q.push_back(w);
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    import usart_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, gie = 0, ack = 0;
    logic        ser_in, sync_clk, ser_out, oe, rx_own, irq_e, irq_d, irq_r;
    logic        pe = 0, po, two, sync_on = 0;
    logic [2:0]  addr = 0, sz;
    logic [3:0]  nb = 8;
    logic [7:0]  wdata = 0, rdata, csb_v;
    logic [8:0]  d;
    logic [11:0] fw, got;
    int          err_total = 0, n_tests = 0;
    always #50 clk = ~clk;
    usart_datapath i_usart_datapath (.REF_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GIE_I(gie),
        .TX_DONE_ACK_I(ack), .SER_IN_I(ser_in), .SYNC_CLK_I(sync_clk), .SER_OUT_O(ser_out),
        .SER_OUT_OE_O(oe), .RX_PIN_OWN_O(rx_own), .TX_EMPTY_IRQ_O(irq_e),
        .TX_DONE_IRQ_O(irq_d), .RX_DONE_IRQ_O(irq_r));
    usart_station i_usart_station (.ser_out_i(ser_out), .nbits_i(nb), .par_i(pe),
        .sync_i(sync_on), .ser_in_o(ser_in), .sync_clk_o(sync_clk));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check($sformatf("register %0d", a), 12'(rdata), 12'(e));
    endtask
    task automatic get_frame(output logic [11:0] f);
        f = 'x;
        repeat (600) if (i_usart_station.got_q.size() == 0) @(posedge clk);
        if (i_usart_station.got_q.size() > 0) f = i_usart_station.got_q.pop_front();
    endtask
    function automatic logic [11:0] frame(input logic [8:0] v, input logic [3:0] n,
                                          input logic p, input logic odd);
        logic [8:0] m;
        m = v & ~(9'h1FF << n);
        frame = {3'h0, m} | (12'h001 << (n + p));
        if (p) frame = frame | ({11'h0, ^m ^ odd} << n);
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #3_000_000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_CSA, 8'h20);
        rd_chk(ADDR_CSB, 8'h00);
        rd_chk(ADDR_CSC, 8'h06);
        rd_chk(3'h7, 8'h00);
        wr_reg(ADDR_BAUD_L, 8'h00);
        wr_reg(ADDR_BAUD_H, 8'h00);
        gie <= 1'b1;
        // size codes 0 to 3 and 7, parity off, even, odd, one and two stops, both ways
        for (int i = 0; i < 5; i++) begin
            sz = (i == 4) ? 3'h7 : 3'(i);
            nb = (i == 4) ? 4'd9 : 4'(i + 5);
            pe = i[0];
            po = i[1];
            two = (i == 2);
            d = 9'h1A5 - 9'(i * 23);
            csb_v = 8'hD8 | {5'h0, sz[2], 1'b0, d[8]};
            wr_reg(ADDR_CSC, {2'b00, pe, po, two, sz[1:0], 1'b0});
            wr_reg(ADDR_CSB, csb_v);
            wr_reg(ADDR_CSA, 8'h40);
            check("output owned", 12'(oe), 12'h001);
            check("input owned", 12'(rx_own), 12'h001);
            wr_reg(ADDR_DATA, d[7:0]);
            fw = frame(d, nb, pe, po);
            get_frame(got);
            check("tx frame", got, fw);
            repeat (40) @(posedge clk);
            rd_chk(ADDR_CSA, 8'h60);
            check("done request", 12'(irq_d), 12'h001);
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
            repeat (3) @(posedge clk);
            check("done cleared", 12'(irq_d), 12'h000);
            i_usart_station.send(fw | (12'(two) << (nb + pe + 1)), nb + pe + 1 + two);
            @(posedge clk);
            check("rx request", 12'(irq_r), 12'h001);
            rd_chk(ADDR_CSA, 8'hA0);
            rd_chk(ADDR_CSB, csb_v | {6'h0, nb == 9 && d[8], 1'b0});
            rd_chk(ADDR_DATA, 8'(d & ~(9'h1FF << nb)));
            repeat (3) @(posedge clk);
            check("rx request gone", 12'(irq_r), 12'h000);
            $display("mode %0d done", i);
        end
        // second byte waits in the buffer while the first shifts
        pe = 0;
        nb = 8;
        wr_reg(ADDR_CSC, 8'h06);
        wr_reg(ADDR_CSB, 8'h38);
        check("empty request", 12'(irq_e), 12'h001);
        wr_reg(ADDR_DATA, 8'h11);
        wr_reg(ADDR_DATA, 8'h22);
        rd_chk(ADDR_CSA, 8'h00);
        check("empty request low", 12'(irq_e), 12'h000);
        get_frame(got);
        check("first frame", got, frame(9'h011, 8, 0, 0));
        get_frame(got);
        check("queued frame", got, frame(9'h022, 8, 0, 0));
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        check("masked request", 12'(irq_e), 12'h000);
        gie <= 1'b1;
        $display("buffer test done");
        // disable while a frame is pending must not cut it
        wr_reg(ADDR_CSB, 8'h18);
        wr_reg(ADDR_DATA, 8'h5A);
        wr_reg(ADDR_CSB, 8'h10);
        check("still owned", 12'(oe), 12'h001);
        get_frame(got);
        check("last frame", got, frame(9'h05A, 8, 0, 0));
        repeat (40) @(posedge clk);
        check("released", 12'(oe), 12'h000);
        wr_reg(ADDR_CSA, 8'h40);
        i_usart_station.send(frame(9'h0C6, 8, 0, 0) & 12'h0FF, 9);
        @(posedge clk);
        rd_chk(ADDR_CSA, 8'hB0);
        rd_chk(ADDR_DATA, 8'hC6);
        $display("disable and framing test done");
        // synchronous mode, both directions on the link clock
        sync_on <= 1'b1;
        wr_reg(ADDR_CSC, 8'h46);
        wr_reg(ADDR_CSB, 8'h18);
        wr_reg(ADDR_DATA, 8'hC3);
        get_frame(got);
        check("sync tx frame", got, frame(9'h0C3, 8, 0, 0));
        i_usart_station.send(frame(9'h03C, 8, 0, 0), 9);
        repeat (8) @(posedge clk);
        rd_chk(ADDR_DATA, 8'h3C);
        $display("sync test done");
        report_and_stop();
    end
endmodule
